/* File: twr_pkg.sv */
// constants, types and carriers for the two-wire register responder
// assumes a 100 MHz system clock; the bus clock arrives as its own clock
package twr_pkg;
    localparam logic [6:0] ADDR_DEFAULT = 7'h08; // 0x10 write, 0x11 read
    localparam logic BOOT_FAST = 1'b1;
    localparam logic BOOT_TWO_WIRE = 1'b1;
    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam logic [7:0] CRC_INIT = 8'h00;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam int CLK_MHZ = 100;
    localparam int CYC_PER_MS = CLK_MHZ * 1000;
    localparam int TO_STD_MS = 25;
    localparam int TO_FAST_MS = 5;
    localparam int TO_CTRL_MS = 10;
    localparam int TO_LONG_S = 2;
    localparam int TO_STD_CYC = TO_STD_MS * CYC_PER_MS;
    localparam int TO_FAST_CYC = TO_FAST_MS * CYC_PER_MS;
    localparam int TO_CTRL_CYC = TO_CTRL_MS * CYC_PER_MS;
    localparam int TO_LONG_CYC = TO_LONG_S * 1000 * CYC_PER_MS;
    localparam int TW = 28;

    typedef enum logic [2:0] {
        S_IDLE = 3'h0,
        S_RX = 3'h1,
        S_ACK = 3'h3,
        S_TX = 3'h2,
        S_MACK = 3'h6
    } twr_state_t;

    typedef enum logic [2:0] {
        PH_ADDR = 3'h0,
        PH_REG = 3'h1,
        PH_DATA = 3'h2,
        PH_WCRC = 3'h3,
        PH_RDATA = 3'h4,
        PH_RCRC = 3'h5
    } twr_phase_t;

    typedef struct packed {
        logic two_wire;
        logic fast;
        logic [6:0] addr;
    } twr_cfg_t;

    typedef struct packed {
        logic valid;
        logic [7:0] addr;
        logic [7:0] data;
    } twr_wr_t;

    typedef struct packed {
        logic [2:0] scl_s;
        logic [2:0] sda_s;
        logic [2:0] tgl_s;
        logic scl_f;
        logic sda_f;
        logic tgl_seen;
        logic booted;
        logic cu_d;
        twr_cfg_t cfg;
        twr_state_t state;
        twr_phase_t phase;
        logic [2:0] cnt;
        logic done;
        logic ack;
        logic rw;
        logic [7:0] sh;
        logic [7:0] ptr;
        logic [7:0] acc;
        logic [7:0] wdat;
        logic sda_oe;
        twr_wr_t wr;
        logic crc_fail;
        logic to_hit;
        logic in_frame;
        logic [TW-1:0] low_cnt;
        logic [TW-1:0] cum_cnt;
    } twr_st_t;

    typedef struct packed {
        logic bit_val;
        logic tgl;
    } twr_link_t;
endpackage

/* File: twr_responder.sv */
// two-wire register responder with optional per-byte crc and clock-low timeouts
// assumes open-drain sda/scl resolved outside; registers live behind the user ports
module twr_responder #(
    parameter logic [twr_pkg::TW-1:0] P_STD = twr_pkg::TW'(twr_pkg::TO_STD_CYC),
    parameter logic [twr_pkg::TW-1:0] P_FAST = twr_pkg::TW'(twr_pkg::TO_FAST_CYC),
    parameter logic [twr_pkg::TW-1:0] P_CTRL = twr_pkg::TW'(twr_pkg::TO_CTRL_CYC),
    parameter logic [twr_pkg::TW-1:0] P_LONG = twr_pkg::TW'(twr_pkg::TO_LONG_CYC)
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic link_scl,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic otp_written,
    input wire twr_pkg::twr_cfg_t otp_cfg,
    input wire twr_pkg::twr_cfg_t reg_cfg,
    input wire logic config_update,
    input wire logic swap_to_two_wire_cmd,
    input wire logic timeout_en,
    input wire logic crc_en,
    input wire logic [7:0] rd_data,
    output logic [7:0] rd_addr,
    output twr_pkg::twr_wr_t wr,
    output logic two_wire_active,
    output logic fast_mode,
    output logic crc_fail,
    output logic timeout_reset
);
    twr_pkg::twr_st_t st;
    twr_pkg::twr_st_t n;
    twr_pkg::twr_link_t lk;
    logic fall;
    logic start;
    logic stop;
    logic ev;
    logic tnew;
    logic [7:0] b;
    logic [twr_pkg::TW-1:0] lim;
    logic trig;

    function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
        logic [7:0] r;
        r = c ^ d;
        for (int i = 0; i < 8; i++) begin
            r = r[7] ? ({r[6:0], 1'b0} ^ twr_pkg::CRC_POLY) : {r[6:0], 1'b0};
        end
        return r;
    endfunction

    // bus-clock side: sample data on the true rising edge and flag it by a toggle
    always_ff @(posedge link_scl or negedge reset_n) begin
        if (!reset_n) begin
            lk <= '0;
        end else begin
            lk.bit_val <= sda_in;
            lk.tgl <= ~lk.tgl;
        end
    end

    always_comb begin
        n = st;
        n.wr.valid = 1'b0;
        n.crc_fail = 1'b0;
        n.to_hit = 1'b0;
        n.scl_s = {st.scl_s[1:0], scl_in};
        n.sda_s = {st.sda_s[1:0], sda_in};
        n.tgl_s = {st.tgl_s[1:0], lk.tgl};
        if (st.scl_s[1] == st.scl_s[2]) begin
            n.scl_f = st.scl_s[2];
        end
        if (st.sda_s[1] == st.sda_s[2]) begin
            n.sda_f = st.sda_s[2];
        end
        tnew = (st.tgl_s[1] == st.tgl_s[2]) ? st.tgl_s[2] : st.tgl_seen;
        // captured bit is held until the next bus edge, so it is stable once the toggle lands
        ev = tnew != st.tgl_seen;
        n.tgl_seen = tnew;
        fall = st.scl_f & ~n.scl_f;
        start = st.scl_f & n.scl_f & st.sda_f & ~n.sda_f;
        stop = st.scl_f & n.scl_f & ~st.sda_f & n.sda_f;
        b = {st.sh[6:0], lk.bit_val};

        // straps are caught on the first edge after reset release
        if (!st.booted) begin
            n.booted = 1'b1;
            if (otp_written) begin
                n.cfg = otp_cfg;
            end else begin
                n.cfg.two_wire = twr_pkg::BOOT_TWO_WIRE;
                n.cfg.fast = twr_pkg::BOOT_FAST;
                n.cfg.addr = twr_pkg::ADDR_DEFAULT;
            end
        end
        n.cu_d = config_update;
        if (st.cu_d && !config_update) begin
            n.cfg = reg_cfg;
        end
        if (swap_to_two_wire_cmd) begin
            n.cfg.two_wire = 1'b1;
        end

        if (stop) begin
            n.state = twr_pkg::S_IDLE;
            n.sda_oe = 1'b0;
            n.acc = twr_pkg::CRC_INIT;
            n.in_frame = 1'b0;
            n.done = 1'b0;
        end else if (start && st.cfg.two_wire) begin
            // repeated start keeps the running crc
            n.state = twr_pkg::S_RX;
            n.phase = twr_pkg::PH_ADDR;
            n.cnt = 3'h0;
            n.done = 1'b0;
            n.sda_oe = 1'b0;
            n.in_frame = 1'b1;
        end else begin
            unique case (st.state)
                twr_pkg::S_IDLE: begin
                    n.sda_oe = 1'b0;
                end
                twr_pkg::S_RX: begin
                    if (ev) begin
                        n.sh = b;
                        n.cnt = st.cnt + 3'h1;
                        if (st.cnt == twr_pkg::LAST_BIT) begin
                            n.done = 1'b1;
                            n.ack = 1'b1;
                            unique case (st.phase)
                                twr_pkg::PH_ADDR: begin
                                    if (b[7:1] == st.cfg.addr) begin
                                        n.rw = b[0];
                                        n.acc = crc8(st.acc, b);
                                        n.phase = b[0] ? twr_pkg::PH_RDATA : twr_pkg::PH_REG;
                                    end else begin
                                        n.ack = 1'b0;
                                    end
                                end
                                twr_pkg::PH_REG: begin
                                    n.ptr = b;
                                    n.acc = crc8(st.acc, b);
                                    n.phase = twr_pkg::PH_DATA;
                                end
                                twr_pkg::PH_DATA: begin
                                    if (crc_en) begin
                                        n.wdat = b;
                                        n.acc = crc8(st.acc, b);
                                        n.phase = twr_pkg::PH_WCRC;
                                    end else begin
                                        n.wr = '{valid: 1'b1, addr: st.ptr, data: b};
                                        n.ptr = st.ptr + 8'h01;
                                    end
                                end
                                twr_pkg::PH_WCRC: begin
                                    n.acc = twr_pkg::CRC_INIT;
                                    if (b == st.acc) begin
                                        n.wr = '{valid: 1'b1, addr: st.ptr, data: st.wdat};
                                        n.ptr = st.ptr + 8'h01;
                                        n.phase = twr_pkg::PH_DATA;
                                    end else begin
                                        n.ack = 1'b0;
                                        n.crc_fail = 1'b1;
                                    end
                                end
                                default: begin
                                    n.ack = 1'b0;
                                end
                            endcase
                        end
                    end
                    if (fall && st.done) begin
                        n.done = 1'b0;
                        n.sda_oe = st.ack;
                        n.state = st.ack ? twr_pkg::S_ACK : twr_pkg::S_IDLE;
                    end
                end
                twr_pkg::S_ACK: begin
                    if (fall) begin
                        n.cnt = 3'h0;
                        if (st.phase == twr_pkg::PH_RDATA) begin
                            n.state = twr_pkg::S_TX;
                            n.sh = rd_data;
                            n.sda_oe = ~rd_data[7];
                            n.acc = crc8(st.acc, rd_data);
                        end else begin
                            n.state = twr_pkg::S_RX;
                            n.sda_oe = 1'b0;
                        end
                    end
                end
                twr_pkg::S_TX: begin
                    if (ev) begin
                        n.cnt = st.cnt + 3'h1;
                        if (st.cnt == twr_pkg::LAST_BIT) begin
                            n.done = 1'b1;
                        end
                    end
                    if (fall) begin
                        if (st.done) begin
                            n.done = 1'b0;
                            n.sda_oe = 1'b0;
                            n.state = twr_pkg::S_MACK;
                            if (st.phase == twr_pkg::PH_RDATA) begin
                                n.ptr = st.ptr + 8'h01;
                            end
                        end else begin
                            n.sh = {st.sh[6:0], 1'b0};
                            n.sda_oe = ~st.sh[6];
                        end
                    end
                end
                twr_pkg::S_MACK: begin
                    if (ev) begin
                        n.ack = ~lk.bit_val;
                        n.done = 1'b1;
                    end
                    if (fall && st.done) begin
                        n.done = 1'b0;
                        n.cnt = 3'h0;
                        if (!st.ack) begin
                            n.state = twr_pkg::S_IDLE;
                            n.acc = twr_pkg::CRC_INIT;
                        end else if (st.phase == twr_pkg::PH_RDATA && crc_en) begin
                            n.state = twr_pkg::S_TX;
                            n.phase = twr_pkg::PH_RCRC;
                            n.sh = st.acc;
                            n.sda_oe = ~st.acc[7];
                        end else begin
                            n.state = twr_pkg::S_TX;
                            n.phase = twr_pkg::PH_RDATA;
                            n.sh = rd_data;
                            n.sda_oe = ~rd_data[7];
                            n.acc = crc8(twr_pkg::CRC_INIT, rd_data);
                        end
                    end
                end
            endcase
        end

        // the responder never stretches, so only the low time seen on the line is counted
        lim = st.cfg.fast ? P_FAST : P_STD;
        trig = 1'b0;
        if (!n.scl_f) begin
            if (st.low_cnt != P_LONG) begin
                n.low_cnt = st.low_cnt + 28'h1;
                trig = (st.low_cnt + 28'h1 == P_LONG);
                trig = trig | (timeout_en && st.low_cnt + 28'h1 == lim);
            end
            if (st.in_frame && st.cum_cnt != P_CTRL) begin
                n.cum_cnt = st.cum_cnt + 28'h1;
                trig = trig | (timeout_en && !st.cfg.fast && st.cum_cnt + 28'h1 == P_CTRL);
            end
        end else begin
            n.low_cnt = '0;
        end
        if (start || stop) begin
            n.cum_cnt = '0;
        end
        if (trig) begin
            n.to_hit = 1'b1;
            n.state = twr_pkg::S_IDLE;
            n.sda_oe = 1'b0;
            n.acc = twr_pkg::CRC_INIT;
            n.in_frame = 1'b0;
            n.done = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            st <= '{scl_f: 1'b1, sda_f: 1'b1, scl_s: 3'h7, sda_s: 3'h7,
                    state: twr_pkg::S_IDLE, phase: twr_pkg::PH_ADDR, default: '0};
        end else begin
            st <= n;
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe = st.sda_oe;
    assign rd_addr = st.ptr;
    assign wr = st.wr;
    assign two_wire_active = st.cfg.two_wire;
    assign fast_mode = st.cfg.fast;
    assign crc_fail = st.crc_fail;
    assign timeout_reset = st.to_hit;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);

    sequence rd_byte_done_s;
        st.state == twr_pkg::S_TX && fall && st.done && st.phase == twr_pkg::PH_RDATA;
    endsequence

    sequence crc_next_s;
        st.state == twr_pkg::S_MACK && fall && st.done && st.ack && crc_en
            && st.phase == twr_pkg::PH_RDATA && !stop && !start && !trig;
    endsequence

    swap_now_a: assert property (swap_to_two_wire_cmd |=> two_wire_active)
        else $error("swap did not select two-wire");
    cfg_hold_a: assert property ((config_update && st.cu_d) |=> $stable(fast_mode))
        else $error("speed changed inside config update");
    boot_def_a: assert property ((st.booted && !$past(st.booted) && !$past(otp_written))
        |-> (fast_mode && two_wire_active && st.cfg.addr == twr_pkg::ADDR_DEFAULT))
        else $error("wrong unprogrammed boot settings");
    addr_miss_a: assert property ((ev && st.state == twr_pkg::S_RX && st.phase == twr_pkg::PH_ADDR
        && st.cnt == twr_pkg::LAST_BIT && b[7:1] != st.cfg.addr && !stop && !start && !trig)
        |=> !st.ack ##1 !sda_oe)
        else $error("foreign address acknowledged");
    wcrc_bad_a: assert property ((crc_fail && st.state == twr_pkg::S_RX)
        |-> !st.ack ##1 (!sda_oe)[*4])
        else $error("bad crc not refused");
    wr_inc_a: assert property (wr.valid |-> rd_addr == wr.addr + 8'h01)
        else $error("write address not advanced");
    rd_inc_a: assert property (rd_byte_done_s and (!stop && !start && !trig)
        |=> rd_addr == $past(rd_addr) + 8'h01)
        else $error("read address not advanced");
    stop_clr_a: assert property (stop |=> (st.acc == 8'h00 && st.state == twr_pkg::S_IDLE))
        else $error("stop did not clear crc");
    crc_tx_a: assert property (crc_next_s |=> (st.phase == twr_pkg::PH_RCRC
        && st.sh == $past(st.acc) && sda_oe == ~$past(st.acc[7])))
        else $error("crc byte not sent after data");
    to_idle_a: assert property (timeout_reset |-> (st.state == twr_pkg::S_IDLE && !sda_oe)
        ##1 (st.low_cnt != 28'h0 || st.scl_f))
        else $error("timeout did not reset interface");
endmodule

/* File: twr_host_model.sv */
// bus controller model that drives the two-wire link from the host side
// assumes sda is open-drain, resolved by the bench with a pull-up; scl is driven directly and stands high between frames
module twr_host (
    output logic scl,
    output logic sda_low,
    input wire logic sda
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HALF = 80;

    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    // also serves as repeated start: sda is released while scl is low first
    task automatic start();
        sda_low = 1'b0;
        #HALF scl = 1'b1;
        #HALF sda_low = 1'b1;
        #HALF scl = 1'b0;
    endtask

    task automatic stop();
        #20 sda_low = 1'b1;
        #(HALF - 20) scl = 1'b1;
        #HALF sda_low = 1'b0;
        #HALF;
    endtask

    task automatic put_bit(input logic b);
        #20 sda_low = !b;
        #(HALF - 20) scl = 1'b1;
        #HALF scl = 1'b0;
    endtask

    // sample mid high phase, well after the responder's 3-4 clock output delay
    task automatic get_bit(output logic b);
        #20 sda_low = 1'b0;
        #(HALF - 20) scl = 1'b1;
        #(HALF / 2) b = sda;
        #(HALF / 2) scl = 1'b0;
    endtask

    task automatic send(input logic [7:0] v, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            put_bit(v[i]);
        end
        get_bit(b);
        ack = !b;
    endtask

    // ack on every byte but the last keeps the block read going
    task automatic recv(output logic [7:0] v, input logic ack);
        for (int i = 7; i >= 0; i--) begin
            get_bit(v[i]);
        end
        put_bit(!ack);
    endtask

    task automatic hold(input int n);
        scl = 1'b0;
        #(n * 10) scl = 1'b1;
        #HALF;
    endtask
endmodule

/* File: testbench.sv */
// self-checking bench for the two-wire responder with a behavioural register map
// assumes the host model file is compiled first; timeouts shortened by parameter
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic config_update = 1'b0;
    logic swap = 1'b0;
    logic timeout_en = 1'b0;
    logic crc_en = 1'b0;
    twr_pkg::twr_cfg_t reg_cfg = '0;
    logic otp_written = 1'b0;
    twr_pkg::twr_cfg_t otp_cfg = '0;
    wire scl;
    wire sda_w;
    logic sda_low, sda_out, sda_oe, two_wire_active, fast_mode, crc_fail, timeout_reset;
    logic [7:0] rd_addr;
    twr_pkg::twr_wr_t wr;
    logic [7:0] mem [256];
    wire [7:0] rd_data = mem[rd_addr];
    int fail_count = 0;
    int comparisons = 0;
    int to_cnt = 0;
    int cf_cnt = 0;
    int c1 = 0;
    logic [15:0] wq [$];
    logic [15:0] eq [$];
    logic [7:0] crc, v;
    logic [7:0] wa = 8'h10;
    logic ack;
    logic e_tw = 1'b1;
    logic e_f = 1'b1;

    always #5 clock = ~clock;
    // pull-up on sda: released means high
    assign sda_w = !(sda_low | (sda_oe & !sda_out));

    twr_host host (.scl(scl), .sda_low(sda_low), .sda(sda_w));

    twr_responder #(.P_STD(28'd2000), .P_FAST(28'd500), .P_CTRL(28'd1500),
        .P_LONG(28'd4000)) DUT (
        .clock(clock), .reset_n(reset_n), .link_scl(scl), .scl_in(scl), .sda_in(sda_w),
        .sda_out(sda_out), .sda_oe(sda_oe), .otp_written(otp_written), .otp_cfg(otp_cfg),
        .reg_cfg(reg_cfg), .config_update(config_update), .swap_to_two_wire_cmd(swap),
        .timeout_en(timeout_en), .crc_en(crc_en), .rd_data(rd_data), .rd_addr(rd_addr),
        .wr(wr), .two_wire_active(two_wire_active), .fast_mode(fast_mode),
        .crc_fail(crc_fail), .timeout_reset(timeout_reset));

    always @(posedge clock) begin
        if (wr.valid) wq.push_back({wr.addr, wr.data});
        if (timeout_reset) to_cnt++;
        if (crc_fail) cf_cnt++;
    end

    function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
        logic [7:0] x;
        x = c ^ d;
        for (int i = 0; i < 8; i++) x = x[7] ? {x[6:0], 1'b0} ^ 8'h07 : {x[6:0], 1'b0};
        return x;
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t ns: seen 0x%h expected 0x%h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task automatic wb(input logic [7:0] b, input logic e);
        host.send(b, ack);
        crc = crc8(crc, b);
        check(16'(ack), 16'(e));
    endtask

    task automatic write_txn(input logic [7:0] r, input int n, input int bad);
        logic [7:0] d;
        host.start();
        crc = 8'h00;
        wb(wa, 1'b1);
        wb(r, 1'b1);
        for (int i = 0; i < n; i++) begin
            d = 8'($urandom);
            wb(d, 1'b1);
            if (crc_en) begin
                host.send(crc ^ 8'(i == bad), ack);
                check(16'(ack), 16'(i != bad));
                crc = 8'h00;
                if (i == bad) break;
            end
            eq.push_back({8'(r + i), d});
        end
        host.stop();
        repeat (10) @(posedge clock);
        check(16'(wq.size()), 16'(eq.size()));
        while (wq.size() > 0 && eq.size() > 0) check(wq.pop_front(), eq.pop_front());
        wq.delete();
        eq.delete();
    endtask

    task automatic read_txn(input logic [7:0] r, input int n, input logic rs);
        logic [7:0] d;
        host.start();
        crc = 8'h00;
        wb(wa, 1'b1);
        wb(r, 1'b1);
        if (!rs) begin
            host.stop();
            crc = 8'h00;
        end
        host.start();
        wb(wa | 8'h01, 1'b1);
        for (int i = 0; i < n; i++) begin
            host.recv(d, crc_en || i < n - 1);
            crc = crc8(crc, d);
            check(16'(d), 16'(mem[8'(r + i)]));
            if (crc_en) begin
                host.recv(d, i < n - 1);
                check(16'(d), 16'(crc));
                crc = 8'h00;
            end
        end
        // after the final nack the responder must have let go of sda
        host.recv(d, 1'b0);
        check(16'(d), 16'h00ff);
        host.stop();
    endtask

    task automatic hold(input int n, input int exp, input logic en);
        int c0;
        @(negedge clock);
        timeout_en = en;
        c0 = to_cnt;
        host.hold(n);
        repeat (5) @(posedge clock);
        check(16'(to_cnt - c0), 16'(exp));
    endtask

    task automatic cfg(input logic tw, input logic f, input logic [6:0] a);
        @(negedge clock);
        reg_cfg = '{two_wire: tw, fast: f, addr: a};
        config_update = 1'b1;
        repeat (4) @(negedge clock);
        check(16'({two_wire_active, fast_mode}), 16'({e_tw, e_f}));
        config_update = 1'b0;
        repeat (3) @(negedge clock);
        e_tw = tw;
        e_f = f;
        check(16'({two_wire_active, fast_mode}), 16'({e_tw, e_f}));
        wa = {a, 1'b0};
    endtask

    initial begin
        v = 8'($urandom(34));
        foreach (mem[i]) mem[i] = 8'($urandom);
        repeat (6) @(posedge clock);
        @(negedge clock) reset_n = 1'b1;
        repeat (3) @(negedge clock);
        check(16'({two_wire_active, fast_mode, rd_addr}), 16'h0300);
        $display("test boot done");
        write_txn(8'hfe, 3, -1);
        read_txn(8'hfe, 3, 1'b1);
        $display("test block transfers done");
        @(negedge clock) crc_en = 1'b1;
        write_txn(8'h20, 1, -1);
        write_txn(8'h40, 3, -1);
        v = 8'(cf_cnt);
        write_txn(8'h60, 3, 1);
        check(16'(8'(cf_cnt) - v), 16'h0001);
        read_txn(8'h40, 1, 1'b1);
        read_txn(8'h40, 1, 1'b0);
        read_txn(8'h10, 3, 1'b1);
        @(negedge clock) crc_en = 1'b0;
        $display("test crc done");
        hold(600, 1, 1'b1);
        hold(600, 0, 1'b0);
        hold(4100, 1, 1'b0);
        $display("test fast timeouts done");
        cfg(1'b1, 1'b0, 7'h2a);
        host.start();
        wb(8'h10, 1'b0);
        host.stop();
        write_txn(8'h05, 2, -1);
        hold(2100, 1, 1'b1);
        // a fast-speed limit would fire here, the slow one must not
        hold(1000, 0, 1'b1);
        // two short lows inside one frame add up past the controller limit
        c1 = to_cnt;
        host.start();
        host.hold(1000);
        host.hold(1000);
        host.stop();
        repeat (5) @(posedge clock);
        check(16'(to_cnt - c1), 16'h0001);
        $display("test address and speed done");
        cfg(1'b0, 1'b0, 7'h2a);
        host.start();
        wb(wa, 1'b0);
        host.stop();
        @(negedge clock) swap = 1'b1;
        @(negedge clock) swap = 1'b0;
        @(negedge clock);
        check(16'(two_wire_active), 16'h0001);
        write_txn(8'h07, 1, -1);
        $display("test swap done");
        // second reset with programmed boot settings: slow speed, new address
        @(negedge clock) reset_n = 1'b0;
        otp_written = 1'b1;
        otp_cfg = '{two_wire: 1'b1, fast: 1'b0, addr: 7'h33};
        repeat (3) @(negedge clock);
        reset_n = 1'b1;
        repeat (3) @(negedge clock);
        check(16'({two_wire_active, fast_mode, rd_addr}), 16'h0200);
        wa = 8'h66;
        write_txn(8'h09, 1, -1);
        $display("test otp boot done");
        wrap_up();
    end

    initial begin
        #900000;
        fail_count++;
        wrap_up();
    end
endmodule
